/* dv/ahb_host.sv */
`timescale 1ns/10ps
module ahb_host (
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata
);
	// idle bus at time zero
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end
	// one single word transfer: address phase held until ready, then data phase
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= w ? d : ~hwdata;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		r = hrdata;
		hsel <= 1'b0;
		hwdata <= ~hwdata; // released data no longer shows the word
	endtask : xfer
endmodule : ahb_host

/* dv/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	localparam int TW = 10;
	logic          hclk = 1'b0;
	logic          hresetn = 1'b0;
	logic          hsel, hwrite, hreadyout, hresp, full, pin_o, pin_oe, tmode, irq;
	logic [31:0]   haddr, hwdata, hrdata;
	logic [1:0]    htrans;
	logic [2:0]    hsize, cv, hold;
	logic [TW-1:0] raw_v [3] = '{10'h0, 10'h0, 10'h0};
	logic [TW-1:0] r1_c, lo_c, r2_c;
	logic [2:0]    vld = 3'h0;
	logic [7:0]    lo_min = 8'hFF;
	logic          ce_in = 1'b1;
	logic [31:0]   rng = 32'h31;
	logic [31:0]   exp_q [$];
	logic          rd_pend = 1'b0;
	int            fails = 0;
	int            n_compared = 0;
	logic [7:0]    rst_tab [8] = '{8'h64, 8'h64, 8'h64, 8'h44, 8'h40, 8'h00, 8'h00, 8'h00};
	always #10 hclk = ~hclk;
	ahb_host host (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
	thermal_limit_hysteresis_offset #(.TW(TW)) uut (
		.hclk, .hresetn, .ce(ce_in), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
		.hreadyout, .hresp, .hrdata, .remote_one_temp(raw_v[0]), .remote_one_valid(vld[0]),
		.local_temp(raw_v[1]), .local_valid(vld[1]), .remote_two_temp(raw_v[2]), .remote_two_valid(vld[2]),
		.remote_one_minimum_temp_threshold(8'hFF), .local_minimum_temp_threshold(lo_min),
		.remote_two_minimum_temp_threshold(8'hFF), .remote_one_temp_corr(r1_c), .local_temp_corr(lo_c),
		.remote_two_temp_corr(r2_c), .corr_valid(cv), .fan_full_duty(full), .minimum_fan_duty_hold(hold),
		.overtemp_pin_out(pin_o), .overtemp_pin_oe(pin_oe), .tree_test_mode(tmode), .irq);
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done
	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction : xs
	function automatic logic [8:0] ad(input int k);
		return 9'(32'h1A8 + 4 * k);
	endfunction : ad
	// expected corrected reading: half-degree offset is two quarter steps, clamped
	function automatic logic [TW-1:0] corr(input logic [TW-1:0] raw, input logic [7:0] off);
		int v;
		v = int'(raw) + 2 * int'($signed(off));
		if (v < 0) v = 0;
		if (v > 32'h3FF) v = 32'h3FF;
		return v[TW-1:0];
	endfunction : corr
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		logic [31:0] r;
		host.xfer(1'b1, {23'h0, a}, {24'h0, d}, r);
		@(negedge hclk);
	endtask : wr
	task automatic rd(input logic [8:0] a, input logic [7:0] e);
		logic [31:0] r;
		exp_q.push_back({24'h0, e});
		host.xfer(1'b0, {23'h0, a}, 32'h0, r);
	endtask : rd
	// one reading pulse, then let state and status settle
	task automatic temp(input int ch, input logic [TW-1:0] raw);
		@(posedge hclk);
		raw_v[ch] <= raw;
		vld[ch] <= 1'b1;
		@(posedge hclk);
		vld <= 3'h0;
		@(posedge hclk);
		@(negedge hclk);
	endtask : temp
	// read data phase: oldest note against what the slave returns
	always @(posedge hclk) begin
		if (rd_pend) chk("hrdata", exp_q.pop_front(), hrdata);
		rd_pend <= hsel && hreadyout && htrans[1] && !hwrite;
	end
	// watchdog against a hung handshake
	initial begin
		repeat (6000) @(posedge hclk);
		fails++;
		test_done();
	end
	initial begin
		logic [7:0]    v;
		logic [TW-1:0] r;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		for (int k = 0; k < 8; k++) rd(ad(k), rst_tab[k]);
		rd(9'h1F0, 8'h00);
		for (int k = 0; k < 8; k++) begin
			v = 8'(xs());
			if (k == 5) v = v & 8'h01;
			if (k == 3) v = v | 8'h44;
			if (k == 4) v = (v | 8'h40) & 8'hF0;
			wr(ad(k), v);
			rd(ad(k), v);
			wr(ad(k), rst_tab[k]);
		end
		wr(ad(5), 8'h01);
		chk("tree_test_mode", 32'h1, {31'h0, tmode});
		wr(ad(5), 8'h00);
		chk("tree_test_mode", 32'h0, {31'h0, tmode});
		$display("end registers");
		for (int k = 0; k < 8; k++) begin
			v = 8'(xs());
			r = 10'(xs()) & 10'h17F;
			wr(ad(6 + k % 2), v);
			temp(k % 2, r);
			chk("corr", corr(r, v), k % 2 ? lo_c : r1_c);
		end
		wr(ad(6), 8'h00);
		wr(ad(7), 8'h00);
		temp(2, 10'h155);
		chk("remote_two_temp_corr", 32'h155, r2_c);
		temp(0, 10'h000);
		temp(1, 10'h000);
		chk("fan_full_duty", 32'h0, full);
		wr(9'h1E4, 8'h07);
		rd(9'h1E4, 8'h00);
		$display("end offsets");
		wr(9'h1E0, 8'h02);
		wr(9'h1E8, 8'h07);
		temp(1, 10'h190);
		chk("fan_full_duty", 32'h0, full);
		temp(1, 10'h191);
		chk("fan_full_duty", 32'h1, full);
		chk("overtemp_pin_oe", 32'h1, pin_oe);
		chk("irq", 32'h1, irq);
		rd(9'h1E4, 8'h02);
		rd(9'h1EC, 8'h42);
		rd(9'h1E8, 8'h07);
		temp(1, 10'h180);
		chk("fan_full_duty", 32'h1, full);
		chk("overtemp_pin_oe", 32'h0, pin_oe);
		temp(1, 10'h17F);
		chk("fan_full_duty", 32'h0, full);
		wr(ad(3), 8'h84);
		temp(0, 10'h191);
		temp(0, 10'h170);
		chk("fan_full_duty", 32'h1, full);
		temp(0, 10'h16F);
		chk("fan_full_duty", 32'h0, full);
		wr(9'h1E4, 8'h07);
		chk("irq", 32'h0, irq);
		wr(ad(0), 8'h80);
		temp(0, 10'h3F0);
		chk("fan_full_duty", 32'h0, full);
		$display("end fail-safe");
		@(posedge hclk);
		lo_min <= 8'h32;
		temp(1, 10'hC9);
		chk("minimum_fan_duty_hold", 32'h2, hold);
		temp(1, 10'hB9);
		chk("minimum_fan_duty_hold", 32'h2, hold);
		temp(1, 10'hB8);
		chk("minimum_fan_duty_hold", 32'h0, hold);
		$display("end minimum run");
		@(posedge hclk);
		ce_in <= 1'b0;
		temp(1, 10'h3FF);
		chk("local_temp_corr", 32'hB8, lo_c);
		chk("fan_full_duty", 32'h0, full);
		@(posedge hclk);
		ce_in <= 1'b1;
		$display("end clock enable");
		wr(9'h1E0, 8'h01);
		rd(9'h1E0, 8'h01);
		wr(ad(1), 8'h11);
		rd(ad(1), 8'h64);
		wr(ad(7), 8'h05);
		rd(ad(7), 8'h00);
		$display("end lock");
		test_done();
	end
endmodule : tb_top

/* dv/thermal_limit_sva.sv */
`timescale 1ns/10ps
module thermal_limit_chk #(
	parameter int TW = 10
) (
	input wire logic          hclk,
	input wire logic          hresetn,
	input wire logic          ce,
	input wire logic          hsel,
	input wire logic [1:0]    htrans,
	input wire logic          hwrite,
	input wire logic          hready,
	input wire logic          hreadyout,
	input wire logic          hresp,
	input wire logic          remote_one_valid,
	input wire logic          local_valid,
	input wire logic          remote_two_valid,
	input wire logic [TW-1:0] local_temp_corr,
	input wire logic [2:0]    corr_valid,
	input wire logic          fan_full_duty,
	input wire logic [2:0]    minimum_fan_duty_hold,
	input wire logic          overtemp_pin_out,
	input wire logic          overtemp_pin_oe,
	input wire logic          tree_test_mode
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic any_take;
	logic wr_take;
	// a reading or a register write taken at this edge
	assign any_take = ce && (remote_one_valid || local_valid || remote_two_valid);
	assign wr_take  = ce && hsel && hready && htrans[1] && hwrite;
	sequence s_local_take;
		ce && local_valid;
	endsequence
	sequence s_local_idle;
		!(ce && local_valid);
	endsequence
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready okay");
	a_corr_pulse: assert property (s_local_take |=> corr_valid[1])
		else $error("no corrected pulse after local reading");
	a_corr_hold: assert property (s_local_idle |=> $stable(local_temp_corr))
		else $error("local corrected value moved without reading");
	a_corr_cause: assert property (corr_valid != 3'h0 |-> $past(any_take))
		else $error("corrected pulse without reading");
	a_duty_cause: assert property ($changed(fan_full_duty) |-> $past(any_take))
		else $error("full duty changed without reading");
	a_minrun_cause: assert property ($changed(minimum_fan_duty_hold) |-> $past(any_take))
		else $error("minimum hold changed without reading");
	a_test_cause: assert property ($changed(tree_test_mode) |-> $past(wr_take, 2))
		else $error("test mode changed without write");
	a_pin_needs_duty: assert property (overtemp_pin_oe |-> fan_full_duty)
		else $error("pin driven without full duty");
	a_pin_out_low: assert property (!overtemp_pin_out)
		else $error("pin output level not low");
endmodule : thermal_limit_chk

bind thermal_limit_hysteresis_offset thermal_limit_chk #(.TW(TW)) chk_i (
	.hclk, .hresetn, .ce, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
	.remote_one_valid, .local_valid, .remote_two_valid, .local_temp_corr, .corr_valid,
	.fan_full_duty, .minimum_fan_duty_hold, .overtemp_pin_out, .overtemp_pin_oe, .tree_test_mode);

/* src/temp_channel.sv */
`timescale 1ns/10ps
`include "thermal_consts.svh"

module temp_channel #(
	parameter int TW = 10
) (
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  wire logic          ce,
	input  wire logic [TW-1:0] temp_raw,
	input  wire logic          temp_valid,
	input  wire logic [7:0]    offset,
	input  wire logic [7:0]    limit,
	input  wire logic [7:0]    minimum_temp_threshold,
	input  wire logic [3:0]    hyst,
	output logic      [TW-1:0] temp_corr,
	output logic               corr_valid,
	output logic               forced,
	output logic               pin_req,
	output logic               min_run,
	output logic               crit_event
);
	import thermal_pkg::*;

	localparam int W = TW + 2;

	failsafe_state_t fs_reg;
	minrun_state_t   mr_reg;
	logic signed [W-1:0] sum;
	logic        [TW-1:0] corr;
	logic signed [W-1:0] ct, lim4, lim_rel4, tmin4, minimum_temp_threshold_rel4;
	logic                en, over;

	// degrees (signed) to quarter-degree units
	function automatic logic signed [W-1:0] q4(input logic signed [9:0] deg);
		q4 = W'(deg) <<< 2;
	endfunction : q4

	// offset has half-degree lsb, reading quarter-degree lsb; clamp to range
	always_comb begin
		sum = signed'(W'({2'b00, temp_raw})) + signed'({{(W-9){offset[7]}}, offset, 1'b0});
		if (sum < 0) begin
			corr = '0;
		end else if (sum > signed'(W'({2'b00, {TW{1'b1}}}))) begin
			corr = '1;
		end else begin
			corr = sum[TW-1:0];
		end
	end

	// threshold arithmetic
	always_comb begin
		ct        = signed'(W'({2'b00, corr}));
		lim4      = q4(signed'({2'b00, limit}));
		lim_rel4  = q4(signed'({2'b00, limit}) - signed'({6'h00, hyst}));
		tmin4     = q4(signed'({2'b00, minimum_temp_threshold}));
		minimum_temp_threshold_rel4 = q4(signed'({2'b00, minimum_temp_threshold}) - signed'({6'h00, hyst}));
		en        = (limit != `CRIT_DISABLE);
		over      = en && (ct > lim4);
	end

	// corrected reading register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			temp_corr  <= '0;
			corr_valid <= 1'b0;
		end else if (ce) begin
			corr_valid <= temp_valid;
			if (temp_valid) begin
				temp_corr <= corr;
			end
		end
	end

	// fail-safe state, evaluated on each new reading
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fs_reg     <= FS_NORMAL;
			crit_event <= 1'b0;
		end else if (ce) begin
			crit_event <= 1'b0;
			if (temp_valid) begin
				case (fs_reg)
					FS_NORMAL: begin
						if (over) begin
							fs_reg     <= FS_FORCED;
							crit_event <= 1'b1;
						end
					end
					FS_FORCED: begin
						if (!en || (ct < lim_rel4)) begin
							fs_reg <= FS_NORMAL;
						end
					end
					default: fs_reg <= FS_NORMAL;
				endcase
			end
		end
	end

	// overtemperature pin request: exceeded by a quarter degree
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_req <= 1'b0;
		end else if (ce && temp_valid) begin
			pin_req <= en && (ct >= lim4 + `QUARTER_STEP);
		end
	end

	// minimum-temperature run with hysteresis
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mr_reg <= MR_IDLE;
		end else if (ce && temp_valid) begin
			case (mr_reg)
				MR_IDLE: begin
					if (ct > tmin4) begin
						mr_reg <= MR_RUN;
					end
				end
				MR_RUN: begin
					if (ct <= minimum_temp_threshold_rel4) begin
						mr_reg <= MR_IDLE;
					end
				end
				default: mr_reg <= MR_IDLE;
			endcase
		end
	end

	assign forced  = (fs_reg == FS_FORCED);
	assign min_run = (mr_reg == MR_RUN);
endmodule : temp_channel

/* src/thermal_consts.svh */
`ifndef THERMAL_CONSTS_SVH
`define THERMAL_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_R1_CRIT      8'h6A
`define IDX_LOC_CRIT     8'h6B
`define IDX_R2_CRIT      8'h6C
`define IDX_LR1_HYST     8'h6D
`define IDX_R2_HYST      8'h6E
`define IDX_TREE_TEST    8'h6F
`define IDX_R1_OFFSET    8'h70
`define IDX_LOC_OFFSET   8'h71
`define IDX_CONTROL      8'h78
`define IDX_IRQ_STATUS   8'h79
`define IDX_IRQ_MASK     8'h7A
`define IDX_STATE        8'h7B

// reset values
`define RST_CRIT         8'h64
`define RST_LR1_HYST     8'h44
`define RST_R2_HYST      8'h40
`define RST_ZERO         8'h00

// field positions
`define CRIT_DISABLE     8'h80
`define HYST_LO_LSB      0
`define HYST_HI_LSB      4
`define TREE_EN_BIT      0
`define CTRL_LOCK_BIT    0
`define CTRL_PIN_OUT_BIT 1

// a quarter degree in temperature units
`define QUARTER_STEP     12'h001

`endif

/* src/thermal_limit_hysteresis_offset.sv */
// Functional notes
// - any channel above its critical limit forces all fan outputs to full duty
// - critical limit 0x80 disables that channel's full-duty fail-safe
// - full duty holds until temperature falls below limit minus hysteresis
// - fail-safe release uses the same per-channel hysteresis as the fan loops
// - overtemp pin may drive low once a limit is exceeded by a quarter degree
// - hysteresis nibbles: local 3:0, remote one 7:4, remote two 7:4 second register
// - hysteresis spans 0 to 15 degrees and serves the fan and minimum loops
// - below minimum threshold fan runs on until threshold minus hysteresis
// - test enable bit 0 enters tree test mode; clearing it leaves
// - remote one offset, signed half-degree, added to every remote one reading
// - local offset, signed half-degree, added to every local reading
// - once lock bit is set, block registers other than interrupt status and mask are read-only
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/10ps
`include "thermal_consts.svh"

module thermal_limit_hysteresis_offset #(
	parameter int TW = 10
) (
	input  wire logic          hclk,
	input  wire logic          hresetn,
	input  wire logic          ce,
	// ahb-lite slave
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic               hreadyout,
	output logic               hresp,
	output logic      [31:0]   hrdata,
	// raw readings, quarter-degree lsb, from the converter on this clock
	input  wire logic [TW-1:0] remote_one_temp,
	input  wire logic          remote_one_valid,
	input  wire logic [TW-1:0] local_temp,
	input  wire logic          local_valid,
	input  wire logic [TW-1:0] remote_two_temp,
	input  wire logic          remote_two_valid,
	// minimum temperature thresholds, whole degrees
	input  wire logic [7:0]    remote_one_minimum_temp_threshold,
	input  wire logic [7:0]    local_minimum_temp_threshold,
	input  wire logic [7:0]    remote_two_minimum_temp_threshold,
	// results
	output logic      [TW-1:0] remote_one_temp_corr,
	output logic      [TW-1:0] local_temp_corr,
	output logic      [TW-1:0] remote_two_temp_corr,
	output logic      [2:0]    corr_valid,
	output logic               fan_full_duty,
	output logic      [2:0]    minimum_fan_duty_hold,
	output logic               overtemp_pin_out,
	output logic               overtemp_pin_oe,
	output logic               tree_test_mode,
	output logic               irq
);
	import thermal_pkg::*;

	logic [7:0]  r1_crit_reg;
	logic [7:0]  loc_crit_reg;
	logic [7:0]  r2_crit_reg;
	logic [7:0]  lr1_hyst_reg;
	logic [7:0]  r2_hyst_reg;
	logic        tree_en_reg;
	logic [7:0]  r1_off_reg;
	logic [7:0]  loc_off_reg;
	logic        lock_reg;
	logic        pin_out_reg;
	logic [2:0]  irq_sts_reg;
	logic [2:0]  irq_mask_reg;
	logic        wr_pend_reg;
	logic [7:0]  wr_idx_reg;
	logic [31:0] rdata_next;
	logic        addr_ok;
	logic        take;
	logic [7:0]  idx;
	logic [2:0]  forced;
	logic [2:0]  pin_req;
	logic [2:0]  min_run;
	logic [2:0]  crit_ev;
	logic        wr_bus;
	logic        wr_cfg;
	logic        wr_r1_crit;
	logic        wr_loc_crit;
	logic        wr_r2_crit;
	logic        wr_lr1_hyst;
	logic        wr_r2_hyst;
	logic        wr_tree;
	logic        wr_r1_off;
	logic        wr_loc_off;
	logic        wr_ctrl;
	logic        wr_sts;
	logic        wr_mask;
	logic [2:0]  w1c;

	// word index from a byte address; out of range gives no match
	function automatic logic idx_hit(input logic [31:0] a, input logic [7:0] i);
		idx_hit = (a[31:10] == 22'h000000) && (a[1:0] == 2'b00) && (a[9:2] == i);
	endfunction : idx_hit

	// one channel per temperature input; remote two arrives already corrected
	temp_channel #(.TW(TW)) u_r1 (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.ce         (ce),
		.temp_raw   (remote_one_temp),
		.temp_valid (remote_one_valid),
		.offset     (r1_off_reg),
		.limit      (r1_crit_reg),
		.minimum_temp_threshold       (remote_one_minimum_temp_threshold),
		.hyst       (lr1_hyst_reg[`HYST_HI_LSB +: 4]),
		.temp_corr  (remote_one_temp_corr),
		.corr_valid (corr_valid[0]),
		.forced     (forced[0]),
		.pin_req    (pin_req[0]),
		.min_run    (min_run[0]),
		.crit_event (crit_ev[0])
	);

	temp_channel #(.TW(TW)) u_loc (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.ce         (ce),
		.temp_raw   (local_temp),
		.temp_valid (local_valid),
		.offset     (loc_off_reg),
		.limit      (loc_crit_reg),
		.minimum_temp_threshold       (local_minimum_temp_threshold),
		.hyst       (lr1_hyst_reg[`HYST_LO_LSB +: 4]),
		.temp_corr  (local_temp_corr),
		.corr_valid (corr_valid[1]),
		.forced     (forced[1]),
		.pin_req    (pin_req[1]),
		.min_run    (min_run[1]),
		.crit_event (crit_ev[1])
	);

	temp_channel #(.TW(TW)) u_r2 (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.ce         (ce),
		.temp_raw   (remote_two_temp),
		.temp_valid (remote_two_valid),
		.offset     (`RST_ZERO),
		.limit      (r2_crit_reg),
		.minimum_temp_threshold       (remote_two_minimum_temp_threshold),
		.hyst       (r2_hyst_reg[`HYST_HI_LSB +: 4]),
		.temp_corr  (remote_two_temp_corr),
		.corr_valid (corr_valid[2]),
		.forced     (forced[2]),
		.pin_req    (pin_req[2]),
		.min_run    (min_run[2]),
		.crit_event (crit_ev[2])
	);

	// system outputs
	assign fan_full_duty         = |forced;
	assign minimum_fan_duty_hold = min_run;
	assign overtemp_pin_out      = 1'b0; // open drain, only pulls low
	assign overtemp_pin_oe       = pin_out_reg && (|pin_req);
	assign tree_test_mode        = tree_en_reg;
	assign irq                   = |(irq_sts_reg & irq_mask_reg);

	// bus answers at once and always okay
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// address phase qualification
	assign take    = hsel && hready && htrans[1];
	assign addr_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00);
	assign idx     = haddr[9:2];

	// write data phase tracking
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg  <= 8'h00;
		end else if (ce) begin
			if (hready) begin
				wr_pend_reg <= take && hwrite && addr_ok;
				wr_idx_reg  <= idx;
			end
		end
	end

	// a write data phase ends on this edge; locked registers ignore it
	assign wr_bus = ce && wr_pend_reg;
	assign wr_cfg = wr_bus && !lock_reg;

	// one write strobe per register; status and mask stay writable under lock
	assign wr_r1_crit  = wr_cfg && (wr_idx_reg == `IDX_R1_CRIT);
	assign wr_loc_crit = wr_cfg && (wr_idx_reg == `IDX_LOC_CRIT);
	assign wr_r2_crit  = wr_cfg && (wr_idx_reg == `IDX_R2_CRIT);
	assign wr_lr1_hyst = wr_cfg && (wr_idx_reg == `IDX_LR1_HYST);
	assign wr_r2_hyst  = wr_cfg && (wr_idx_reg == `IDX_R2_HYST);
	assign wr_tree     = wr_cfg && (wr_idx_reg == `IDX_TREE_TEST);
	assign wr_r1_off   = wr_cfg && (wr_idx_reg == `IDX_R1_OFFSET);
	assign wr_loc_off  = wr_cfg && (wr_idx_reg == `IDX_LOC_OFFSET);
	assign wr_ctrl     = wr_cfg && (wr_idx_reg == `IDX_CONTROL);
	assign wr_sts      = wr_bus && (wr_idx_reg == `IDX_IRQ_STATUS);
	assign wr_mask     = wr_bus && (wr_idx_reg == `IDX_IRQ_MASK);

	// remote one critical limit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r1_crit_reg <= `RST_CRIT;
		end else if (wr_r1_crit) begin
			r1_crit_reg <= hwdata[7:0];
		end
	end

	// local critical limit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			loc_crit_reg <= `RST_CRIT;
		end else if (wr_loc_crit) begin
			loc_crit_reg <= hwdata[7:0];
		end
	end

	// remote two critical limit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r2_crit_reg <= `RST_CRIT;
		end else if (wr_r2_crit) begin
			r2_crit_reg <= hwdata[7:0];
		end
	end

	// local and remote one hysteresis nibbles
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lr1_hyst_reg <= `RST_LR1_HYST;
		end else if (wr_lr1_hyst) begin
			lr1_hyst_reg <= hwdata[7:0];
		end
	end

	// remote two hysteresis nibble
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r2_hyst_reg <= `RST_R2_HYST;
		end else if (wr_r2_hyst) begin
			r2_hyst_reg <= hwdata[7:0];
		end
	end

	// tree test enable, only bit 0 is stored
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tree_en_reg <= 1'b0;
		end else if (wr_tree) begin
			tree_en_reg <= hwdata[`TREE_EN_BIT];
		end
	end

	// remote one offset, signed half degrees
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r1_off_reg <= `RST_ZERO;
		end else if (wr_r1_off) begin
			r1_off_reg <= hwdata[7:0];
		end
	end

	// local offset, signed half degrees
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			loc_off_reg <= `RST_ZERO;
		end else if (wr_loc_off) begin
			loc_off_reg <= hwdata[7:0];
		end
	end

	// control: lock is sticky until reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lock_reg    <= 1'b0;
			pin_out_reg <= 1'b0;
		end else if (wr_ctrl) begin
			lock_reg    <= hwdata[`CTRL_LOCK_BIT];
			pin_out_reg <= hwdata[`CTRL_PIN_OUT_BIT];
		end
	end

	// interrupt status and mask; a new event beats a clear
	assign w1c = wr_sts ? hwdata[2:0] : 3'h0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_sts_reg <= 3'h0;
		end else if (ce) begin
			irq_sts_reg <= (irq_sts_reg & ~w1c) | crit_ev;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_mask_reg <= 3'h0;
		end else if (wr_mask) begin
			irq_mask_reg <= hwdata[2:0];
		end
	end

	// read mux, looked up in the address phase
	always_comb begin
		rdata_next = 32'h00000000;
		if (idx_hit(haddr, `IDX_R1_CRIT)) begin
			rdata_next[7:0] = r1_crit_reg;
		end else if (idx_hit(haddr, `IDX_LOC_CRIT)) begin
			rdata_next[7:0] = loc_crit_reg;
		end else if (idx_hit(haddr, `IDX_R2_CRIT)) begin
			rdata_next[7:0] = r2_crit_reg;
		end else if (idx_hit(haddr, `IDX_LR1_HYST)) begin
			rdata_next[7:0] = lr1_hyst_reg;
		end else if (idx_hit(haddr, `IDX_R2_HYST)) begin
			rdata_next[7:0] = r2_hyst_reg;
		end else if (idx_hit(haddr, `IDX_TREE_TEST)) begin
			rdata_next[`TREE_EN_BIT] = tree_en_reg;
		end else if (idx_hit(haddr, `IDX_R1_OFFSET)) begin
			rdata_next[7:0] = r1_off_reg;
		end else if (idx_hit(haddr, `IDX_LOC_OFFSET)) begin
			rdata_next[7:0] = loc_off_reg;
		end else if (idx_hit(haddr, `IDX_CONTROL)) begin
			rdata_next[`CTRL_LOCK_BIT]    = lock_reg;
			rdata_next[`CTRL_PIN_OUT_BIT] = pin_out_reg;
		end else if (idx_hit(haddr, `IDX_IRQ_STATUS)) begin
			rdata_next[2:0] = irq_sts_reg;
		end else if (idx_hit(haddr, `IDX_IRQ_MASK)) begin
			rdata_next[2:0] = irq_mask_reg;
		end else if (idx_hit(haddr, `IDX_STATE)) begin
			rdata_next[7:0] = {1'b0, overtemp_pin_oe, min_run, forced};
		end
	end

	// read data register, valid through the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (ce && take && !hwrite) begin
			hrdata <= rdata_next;
		end
	end
endmodule : thermal_limit_hysteresis_offset

/* src/thermal_pkg.sv */
package thermal_pkg;
	// fail-safe state of one channel
	typedef enum logic {
		FS_NORMAL,
		FS_FORCED
	} failsafe_state_t;
	// minimum-temperature run state of one channel
	typedef enum logic {
		MR_IDLE,
		MR_RUN
	} minrun_state_t;
endpackage : thermal_pkg
